// ---- verilog/rbs_pkg.sv ----
package rbs_pkg;
    // Address geometry
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int OFFS_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_BANKS = 16;
    localparam int BANK_BYTES = 256;
    // Access window split point and high bank
    localparam logic [7:0] ACC_LOW_TOP = 8'h60;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
    localparam logic [3:0] ACC_LOW_BANK = 4'h0;
    // Bank select register layout
    localparam logic [7:0] BANK_SEL_RESET = 8'h00;
    localparam logic [7:0] BANK_SEL_MASK = 8'h0f;
    // Default implemented-bank map: all sixteen banks present
    localparam logic [15:0] BANK_IMPL_DEFAULT = 16'hffff;

    // Kinds of data access presented by the decoder
    typedef enum logic [1:0] {
        RBS_OP_NONE = 2'b00,
        RBS_OP_DIRECT = 2'b01,
        RBS_OP_MOVE = 2'b10,
        RBS_OP_LOAD_BANK = 2'b11
    } rbs_op_t;

    // One request from the instruction decoder
    typedef struct packed {
        rbs_op_t op;
        logic accessBit;
        logic [7:0] fileOperand;
        logic [11:0] srcAddr;
        logic [11:0] dstAddr;
        logic [7:0] literal;
        logic wrEn;
        logic [7:0] wrData;
    } rbs_req_t;

    // One answer back to the core
    typedef struct packed {
        logic valid;
        logic [7:0] rdData;
        logic bankMissing;
    } rbs_rsp_t;
endpackage : rbs_pkg

// ---- verilog/rbs_addr_map.sv ----
`timescale 1ns/1ps
// Direct-address former: banked path or access window
module rbs_addr_map (
    // Inputs
    input wire logic accessBit,
    input wire logic [3:0] bankSel,
    input wire logic [7:0] fileOperand,
    // Output
    output logic [11:0] dataAddr
);
    // Access bit clear forces window; low part from bank 0, high part from bank 15
    always_comb
    begin
        if (accessBit)
            dataAddr = {bankSel, fileOperand};
        else if (fileOperand < rbs_pkg::ACC_LOW_TOP)
            dataAddr = {rbs_pkg::ACC_LOW_BANK, fileOperand};
        else
            dataAddr = {rbs_pkg::ACC_HIGH_BANK, fileOperand};
    end
endmodule : rbs_addr_map

// ---- verilog/rbs_ram.sv ----
`timescale 1ns/1ps
// Static data RAM, registered read
module rbs_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    // Clock
    input wire logic mclk,
    // Port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge mclk)
    begin
        if (wrEn)
            mem[wrAddr] <= wrData;
    end

    // Registered read port
    always_ff @(posedge mclk)
    begin
        rdData <= mem[rdAddr];
    end
endmodule : rbs_ram

// ---- verilog/rbs_bank_select.sv ----
`timescale 1ns/1ps
module rbs_bank_select #(
    parameter logic [15:0] BANK_IMPL = rbs_pkg::BANK_IMPL_DEFAULT
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Decoder request
    input wire logic reqValid,
    input rbs_pkg::rbs_req_t req,
    // Answer to the core
    output rbs_pkg::rbs_rsp_t rsp,
    // Bank select register view and last formed read address
    output logic [7:0] ramBankSelect,
    output logic [11:0] lastAddr
);
    // Request strobes by kind
    logic isDirect;
    logic isMove;
    logic isLoad;
    logic isAccess;
    logic isWrite;

    // Addresses formed for both memory ports
    logic [11:0] directAddr;
    logic [11:0] rdAddr;
    logic [11:0] wrAddr;
    logic [3:0] rdBank;
    logic [3:0] wrBank;

    // Bank presence seen by both ports
    logic [15:0] bankPresent;
    logic rdImpl;
    logic wrImpl;
    logic rdMissNow;
    logic wrMissNow;

    // Data memory port
    logic ramWrEn;
    logic [7:0] ramRd;

    // Bank select register
    logic [7:0] bankSel_d;
    logic [7:0] bankSel_q;

    // Read tracking for the one-cycle answer
    logic rdPend_d;
    logic rdPend_q;
    logic rdImpl_d;
    logic rdImpl_q;
    logic rdMiss_d;
    logic rdMiss_q;
    logic wrMiss_d;
    logic wrMiss_q;

    // Last formed read address
    logic [11:0] lastAddr_d;
    logic [11:0] lastAddr_q;

    // Answer fields before packing
    logic rspValid;
    logic [7:0] rspData;
    logic rspMiss;

    // One strobe per request kind; a request without its strobe,
    // or with an unused code, touches nothing
    always_comb
    begin
        isDirect = 1'b0;
        isMove = 1'b0;
        isLoad = 1'b0;
        if (reqValid)
        begin
            case (req.op)
                rbs_pkg::RBS_OP_DIRECT:
                begin
                    isDirect = 1'b1;
                end
                rbs_pkg::RBS_OP_MOVE:
                begin
                    isMove = 1'b1;
                end
                rbs_pkg::RBS_OP_LOAD_BANK:
                begin
                    isLoad = 1'b1;
                end
                default:
                begin
                    isDirect = 1'b0;
                    isMove = 1'b0;
                    isLoad = 1'b0;
                end
            endcase
        end
    end

    // Direct and move touch memory; load-bank only the select register
    assign isAccess = isDirect || isMove;
    assign isWrite = isAccess && req.wrEn;

    // Direct address from select or window
    rbs_addr_map u_map (
        .accessBit(req.accessBit),
        .bankSel(bankSel_q[3:0]),
        .fileOperand(req.fileOperand),
        .dataAddr(directAddr)
    );

    // Move ignores the select register entirely; both of its
    // addresses arrive whole from the instruction words
    always_comb
    begin
        if (isMove)
        begin
            rdAddr = req.srcAddr;
            wrAddr = req.dstAddr;
        end
        else
        begin
            rdAddr = directAddr;
            wrAddr = directAddr;
        end
    end

    // Bank number on each port
    assign rdBank = rdAddr[rbs_pkg::ADDR_W-1:rbs_pkg::OFFS_W];
    assign wrBank = wrAddr[rbs_pkg::ADDR_W-1:rbs_pkg::OFFS_W];

    // Presence table, one flag per bank
    for (genvar b = 0; b < rbs_pkg::NUM_BANKS; b++)
    begin : g_bank
        assign bankPresent[b] = BANK_IMPL[b];
    end

    // Implemented-bank lookup for both ports
    assign rdImpl = bankPresent[rdBank];
    assign wrImpl = bankPresent[wrBank];
    assign rdMissNow = isAccess && !rdImpl;
    assign wrMissNow = isAccess && !wrImpl;

    // Writes to a missing bank never reach the array
    assign ramWrEn = isWrite && wrImpl;

    // Sixteen banks of 256 bytes in one array; a read of the
    // location written on the same edge returns the old byte
    rbs_ram #(
        .AW(rbs_pkg::ADDR_W),
        .DW(rbs_pkg::DATA_W)
    ) u_ram (
        .mclk(mclk),
        .wrEn(ramWrEn),
        .wrAddr(wrAddr),
        .wrData(req.wrData),
        .rdAddr(rdAddr),
        .rdData(ramRd)
    );

    // Load-bank takes the literal; the upper nibble is never stored
    always_comb
    begin
        if (isLoad)
        begin
            bankSel_d = req.literal & rbs_pkg::BANK_SEL_MASK;
        end
        else
        begin
            bankSel_d = bankSel_q;
        end
    end

    // Bank select register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bankSel_q <= rbs_pkg::BANK_SEL_RESET;
        end
        else
        begin
            bankSel_q <= bankSel_d;
        end
    end

    // Next values of the read tracking
    always_comb
    begin
        rdPend_d = isAccess;
        rdImpl_d = rdImpl;
        rdMiss_d = rdMissNow;
        wrMiss_d = wrMissNow;
    end

    // Answer pending one cycle after each access
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdPend_q <= 1'b0;
        end
        else
        begin
            rdPend_q <= rdPend_d;
        end
    end

    // Read bank present, gates the read data
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdImpl_q <= 1'b0;
        end
        else
        begin
            rdImpl_q <= rdImpl_d;
        end
    end

    // Read bank missing on the last access
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdMiss_q <= 1'b0;
        end
        else
        begin
            rdMiss_q <= rdMiss_d;
        end
    end

    // Write bank missing on the last access
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrMiss_q <= 1'b0;
        end
        else
        begin
            wrMiss_q <= wrMiss_d;
        end
    end

    // Last formed read address holds between accesses
    always_comb
    begin
        if (isAccess)
        begin
            lastAddr_d = rdAddr;
        end
        else
        begin
            lastAddr_d = lastAddr_q;
        end
    end

    // Last formed address, for observation
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lastAddr_q <= 12'h000;
        end
        else
        begin
            lastAddr_q <= lastAddr_d;
        end
    end

    // The answer goes out for every access, even to a missing
    // bank, so the core still updates its status flags
    assign rspValid = rdPend_q;

    // Missing read bank returns zero
    assign rspData = (rdPend_q && rdImpl_q) ? ramRd : 8'h00;

    // Either port missing is flagged
    assign rspMiss = rdMiss_q || wrMiss_q;

    // Pack the answer for the core
    always_comb
    begin
        rsp.valid = rspValid;
        rsp.rdData = rspData;
        rsp.bankMissing = rspMiss;
    end

    // Select register view, upper nibble forced to zero
    assign ramBankSelect = bankSel_q & rbs_pkg::BANK_SEL_MASK;
    assign lastAddr = lastAddr_q;
endmodule : rbs_bank_select

// ---- test/rbs_core_model.sv ----
`timescale 1ns/1ps
// Decoder stand-in
module rbs_core_model (
    // Fields
    input wire logic [1:0] k,
    input wire logic a,
    input wire logic [7:0] f,
    input wire logic [11:0] s,
    input wire logic [7:0] w,
    // Request
    output rbs_pkg::rbs_req_t req
);
    // Always writes; literal repeats the file operand
    assign req = {k, a, f, s, s ^ 12'h100, f, 1'b1, w};
endmodule : rbs_core_model

// ---- test/rbs_bank_select_asserts.sv ----
`timescale 1ns/1ps
// Port relations
module rbs_bank_select_asserts (
    // Clock, reset
    input wire logic mclk,
    input wire logic rst_n,
    // Ports
    input wire logic reqValid,
    input rbs_pkg::rbs_req_t req,
    input rbs_pkg::rbs_rsp_t rsp,
    input wire logic [7:0] ramBankSelect,
    input wire logic [11:0] lastAddr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Request kinds
    wire d = reqValid && req.op == 2'h1;
    wire m = reqValid && req.op == 2'h2;
    wire l = reqValid && req.op == 2'h3;
    wire w = d && !req.accessBit;
    wire [7:0] f = req.fileOperand;
    top_zero_a: assert property (ramBankSelect[7:4] == 4'h0) else $error("top");
    sel_load_a: assert property (l |=> ramBankSelect[3:0] == $past(req.literal[3:0]))
        else $error("load");
    sel_hold_a: assert property (!l |=> $stable(ramBankSelect)) else $error("hold");
    rsp_pulse_a: assert property (d || m |=> rsp.valid) else $error("valid");
    rsp_quiet_a: assert property (!(d || m) |=> !rsp.valid) else $error("quiet");
    win_low_a: assert property (w && f < 8'h60 |=> lastAddr == $past(f))
        else $error("low");
    win_high_a: assert property (w && f >= 8'h60 |=> lastAddr == {4'hf, $past(f)})
        else $error("high");
    bank_addr_a: assert property (d && req.accessBit |=>
        lastAddr == {$past(ramBankSelect[3:0]), $past(f)}) else $error("bank");
    move_src_a: assert property (m |=> lastAddr == $past(req.srcAddr)) else $error("mv");
endmodule : rbs_bank_select_asserts
bind rbs_bank_select rbs_bank_select_asserts u_chk (.mclk(mclk), .rst_n(rst_n),
    .reqValid(reqValid), .req(req), .rsp(rsp), .ramBankSelect(ramBankSelect),
    .lastAddr(lastAddr));

// ---- test/rbs_bank_select_tb.sv ----
`timescale 1ns/1ps
module rbs_bank_select_tb;
    localparam logic [15:0] IMPL = 16'h80ff;
    logic mclk = 0, rst_n = 0, reqValid = 0, a = 0;
    logic [1:0] k = 0;
    logic [7:0] f = 0, w = 0, x, bs;
    logic [11:0] s = 0;
    logic [3:0] bk = 0;
    int errTotal = 0, nCompared = 0;
    rbs_pkg::rbs_req_t req;
    rbs_pkg::rbs_rsp_t rsp;
    // Clock
    always #2.5 mclk = ~mclk;
    // Decoder and block
    rbs_core_model pm (.k(k), .a(a), .f(f), .s(s), .w(w), .req(req));
    rbs_bank_select #(.BANK_IMPL(IMPL)) dut (.mclk(mclk), .rst_n(rst_n),
        .reqValid(reqValid), .req(req), .rsp(rsp), .ramBankSelect(bs), .lastAddr());
    // Compare, count
    task chk(input string n, input logic [7:0] e, input logic [7:0] v);
        nCompared++;
        if (v !== e)
        begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    // One request
    task go(input logic [1:0] o);
        @(negedge mclk);
        k = o;
        f = x;
        reqValid = 1;
        @(negedge mclk);
        reqValid = 0;
    endtask : go
    // Missing banks read zero
    function automatic logic [7:0] ex(input logic [7:0] v);
        return IMPL[s[11:8]] ? v : 8'h00;
    endfunction : ex
    // Missing flag when either bank is absent
    function automatic logic [7:0] mi(input logic [3:0] b0, input logic [3:0] b1);
        return (IMPL[b0] && IMPL[b1]) ? 8'h00 : 8'h01;
    endfunction : mi
    // Verdict
    task summarize;
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // Watchdog
    initial
    begin
        #30000;
        errTotal++;
        summarize();
    end
    // Random loop, window edges first
    initial
    begin
        x = $urandom(32'hcfba);
        #50 rst_n = 1;
        for (int i = 0; i < 300; i++)
        begin
            a = i < 4 ? 1'b0 : 1'($urandom);
            w = 8'($urandom);
            x = 8'($urandom);
            go(2'h3);
            chk("sel", x & 8'h0f, bs);
            bk = x[3:0];
            x = i < 4 ? 8'h5e + i[7:0] : 8'($urandom);
            s = a ? {bk, x} : {x < 8'h60 ? 4'h0 : 4'hf, x};
            go(2'h1);
            w = ~w;
            go(2'h1);
            chk("rd", ex(~w), rsp.rdData);
            chk("vld", 8'h01, rsp.valid);
            chk("miss", mi(s[11:8], s[11:8]), rsp.bankMissing);
            go(2'h2);
            chk("mv", ex(w), rsp.rdData);
            chk("mvmiss", mi(s[11:8], s[11:8] ^ 4'h1), rsp.bankMissing);
        end
        summarize();
    end
endmodule : rbs_bank_select_tb
